// *** hw/sapc_core.sv ***
// Conversion control, successive approximation and three-state output of the converter.
`timescale 1ns/1ps
`default_nettype none

module sapc_core (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic chip_select_n,
    input wire logic conversion_start_n,
    input wire logic read_n,
    input wire logic power_down_n,
    input wire sapc_pkg::sapc_word_t analog_sample,
    output logic busy,
    output var sapc_pkg::sapc_word_t result_bus,
    output logic result_bus_oe,
    output logic nap_mode,
    output logic sleep_mode
);
    import sapc_pkg::*;

    sapc_state_e state;
    sapc_state_e next_state;
    logic start_prev;
    sapc_word_t target;
    sapc_word_t trial;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [IDX_W-1:0] bit_idx;
    logic [LEAD_W-1:0] lead_cnt;

    wire logic start_fall;
    wire logic start_take;
    wire logic read_active;
    wire logic bit_done;
    wire logic last_bit;
    wire sapc_word_t trial_bit;
    wire logic keep_bit;
    wire logic lead_done;
    wire logic fifo_in_valid;
    wire logic fifo_in_ready;
    wire sapc_word_t fifo_in_data;
    wire logic fifo_out_valid;
    wire logic fifo_out_ready;
    wire sapc_word_t fifo_out_data;
    wire logic pop;

    // Start and read only count while the part is selected.
    assign start_fall = start_prev & ~conversion_start_n & ~chip_select_n;
    // Edges outside idle are dropped, so a running conversion runs to its end.
    assign start_take = start_fall & power_down_n & (state == ST_IDLE);
    assign read_active = ~read_n & ~chip_select_n;
    assign bit_done = (bit_cnt == BIT_CNT_W'(BIT_CYC - 1));
    assign last_bit = (bit_idx == '0);
    assign trial_bit = trial | (sapc_word_t'(1) << bit_idx);
    assign keep_bit = (trial_bit <= target);
    assign lead_done = (lead_cnt == LEAD_W'(LEAD_CYC - 1));
    assign fifo_in_valid = (state == ST_PUSH);
    assign fifo_in_data = sapc_flip(trial);
    // The output latch holds still while the host is reading it.
    assign fifo_out_ready = (state == ST_POP) & ~read_active;
    assign pop = fifo_out_valid & fifo_out_ready;

    sapc_fifo #(
        .WIDTH(RES_BITS),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in_data),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start_take) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (bit_done && last_bit) begin
                    next_state = ST_PUSH;
                end
            end
            ST_PUSH: begin
                if (fifo_in_ready) begin
                    next_state = ST_POP;
                end
            end
            ST_POP: begin
                if (pop) begin
                    next_state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (lead_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state <= ST_IDLE;
            busy <= BUSY_RESET;
            start_prev <= 1'b1;
        end else begin
            state <= next_state;
            busy <= (next_state == ST_IDLE);
            start_prev <= conversion_start_n;
        end
    end

    // Bit decisions run from the most significant bit down on offset binary.
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            target <= WORD_ZERO;
            trial <= WORD_ZERO;
            bit_cnt <= '0;
            bit_idx <= MSB_INDEX;
        end else if (start_take) begin
            target <= sapc_flip(analog_sample);
            trial <= WORD_ZERO;
            bit_cnt <= '0;
            bit_idx <= MSB_INDEX;
        end else if (state == ST_CONV) begin
            bit_cnt <= bit_done ? '0 : bit_cnt + 1'b1;
            if (bit_done) begin
                trial <= keep_bit ? trial_bit : trial;
                bit_idx <= last_bit ? bit_idx : bit_idx - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            lead_cnt <= '0;
        end else begin
            lead_cnt <= (state == ST_LEAD) ? lead_cnt + 1'b1 : '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            result_bus <= WORD_ZERO;
            result_bus_oe <= 1'b0;
            nap_mode <= 1'b0;
            sleep_mode <= 1'b0;
        end else begin
            if (pop) begin
                result_bus <= fifo_out_data;
            end
            result_bus_oe <= read_active;
            nap_mode <= ~power_down_n & ~chip_select_n;
            sleep_mode <= ~power_down_n & chip_select_n;
        end
    end

    // Helper counters for the checks below.
    logic [SPAN_W-1:0] low_cnt;
    logic stalled;
    logic [LEAD_W-1:0] latch_age;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            low_cnt <= '0;
            stalled <= 1'b0;
            latch_age <= '0;
        end else begin
            if (busy) begin
                low_cnt <= '0;
                stalled <= 1'b0;
            end else begin
                low_cnt <= (low_cnt == '1) ? low_cnt : low_cnt + 1'b1;
                stalled <= stalled | (fifo_in_valid & ~fifo_in_ready) | ((state == ST_POP) & ~pop);
            end
            if (pop) begin
                latch_age <= '0;
            end else if (latch_age != '1) begin
                latch_age <= latch_age + 1'b1;
            end
        end
    end

    AST_START_BEGINS: assert property (@(posedge sys_clk) disable iff (!rstn)
        start_take |=> (state == ST_CONV) && !busy)
        else $error("Accepted start edge did not begin a conversion.");

    AST_CYCLE_TIME: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(busy) && !stalled |-> low_cnt <= SPAN_W'(ACQ_CONV_MAX_CYC))
        else $error("Conversion cycle exceeded its longest time.");

    AST_DATA_LEAD: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(busy) |-> latch_age >= LEAD_W'(LEAD_CYC))
        else $error("Busy rose too soon after the result was latched.");

    AST_NAP_SLEEP: assert property (@(posedge sys_clk) disable iff (!rstn)
        !power_down_n |=> (nap_mode == !$past(chip_select_n)) && (sleep_mode == $past(chip_select_n)))
        else $error("Power-down mode does not follow chip select.");

    AST_TWOS_CODE: assert property (@(posedge sys_clk) disable iff (!rstn)
        fifo_in_valid && fifo_in_ready |-> fifo_in_data == sapc_flip(target))
        else $error("Result code does not match the held sample.");

    AST_BUSY_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(busy) |-> !busy [*8] ##1 (state != ST_IDLE))
        else $error("Busy rose while a conversion was running.");

    AST_DESELECT_IGNORED: assert property (@(posedge sys_clk) disable iff (!rstn)
        chip_select_n && (state == ST_IDLE) |=> (state == ST_IDLE) && $stable(target))
        else $error("Start acted while chip select was high.");

    AST_DRIVE_WINDOW: assert property (@(posedge sys_clk) disable iff (!rstn)
        ##1 result_bus_oe == $past(!read_n && !chip_select_n))
        else $error("Data drivers enabled outside the read window.");

    AST_NO_RESTART: assert property (@(posedge sys_clk) disable iff (!rstn)
        (state == ST_CONV) && start_fall |=> $stable(target) && (bit_idx <= $past(bit_idx)))
        else $error("A running conversion was restarted.");

    COV_CONVERSION_DONE: cover property (@(posedge sys_clk) disable iff (!rstn) $rose(busy));
    COV_READ_RESULT: cover property (@(posedge sys_clk) disable iff (!rstn) busy && result_bus_oe);
    COV_READ_STALL: cover property (@(posedge sys_clk) disable iff (!rstn) (state == ST_POP) && read_active);
    COV_NAP: cover property (@(posedge sys_clk) disable iff (!rstn) nap_mode);

endmodule

`default_nettype wire

// *** common/sapc_pkg.sv ***
// Constants, types and helpers shared by the converter control logic.
// Contract
// - A falling start edge in idle, while powered up, begins a conversion.
// - Acquisition plus conversion ends within 2.5 us.
// - Result valid 75 ns before busy rises.
// - Power-down low: nap if selected, else sleep.
// - Output code is two's complement bipolar.
// - Busy low throughout conversion, high when valid.
// - Start and read ignored without chip select.
// - Drive data only while read and select low.
// - Running conversion cannot be restarted.
`default_nettype none

package sapc_pkg;

    localparam int RES_BITS = 14;
    typedef logic [RES_BITS-1:0] sapc_word_t;

    localparam int CLK_PERIOD_PS = 4000;
    localparam int CONV_TIME_NS = 1900;
    localparam int DATA_LEAD_NS = 75;
    localparam int ACQ_CONV_MAX_NS = 2500;

    // Longest times round down, least times round up.
    localparam int CONV_CYC = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int BIT_CYC = CONV_CYC / RES_BITS;
    localparam int LEAD_CYC = (DATA_LEAD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACQ_CONV_MAX_CYC = (ACQ_CONV_MAX_NS * 1000) / CLK_PERIOD_PS;

    localparam int BIT_CNT_W = 6;
    localparam int IDX_W = 4;
    localparam int LEAD_W = 5;
    localparam int SPAN_W = 10;
    localparam int FIFO_DEPTH = 4;

    localparam logic [IDX_W-1:0] MSB_INDEX = 4'hd;
    localparam sapc_word_t BIPOLAR_FLIP = 14'h2000;
    localparam sapc_word_t WORD_ZERO = 14'h0000;
    localparam logic BUSY_RESET = 1'b1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_CONV = 3'b001,
        ST_PUSH = 3'b011,
        ST_POP = 3'b010,
        ST_LEAD = 3'b110
    } sapc_state_e;

    // Moves between offset binary and two's complement.
    function automatic sapc_word_t sapc_flip(input sapc_word_t w);
        sapc_flip = w ^ BIPOLAR_FLIP;
    endfunction

endpackage

`default_nettype wire

// *** hw/sapc_fifo.sv ***
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module sapc_fifo #(
    parameter int WIDTH = 14,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
    logic push;
    logic pop;

    function automatic logic [PTR_W-1:0] step(input logic [PTR_W-1:0] p);
        step = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign in_ready = (count != CNT_W'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = store[rd_ptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= step(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= step(rd_ptr);
            end
            count <= count + CNT_W'(push) - CNT_W'(pop);
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            store[wr_ptr] <= in_data;
        end
    end

endmodule

`default_nettype wire

// *** tb/sapc_host_model.sv ***
// Host model that drives the strobes of the converter.
`timescale 1ns/1ps
`default_nettype none

module sapc_host_model (
    input wire logic sys_clk,
    input wire sapc_pkg::sapc_word_t result_bus,
    input wire logic result_bus_oe,
    output var logic chip_select_n,
    output var logic conversion_start_n,
    output var logic read_n,
    output var logic power_down_n,
    output var sapc_pkg::sapc_word_t analog_sample
);
    import sapc_pkg::*;

    initial begin
        chip_select_n = 1'b1;
        conversion_start_n = 1'b1;
        read_n = 1'b1;
        power_down_n = 1'b1;
        analog_sample = 14'h0000;
    end

    // The sample is inverted after the take edge, so a late sampler is caught.
    task automatic start(input sapc_word_t s, input logic cs);
        @(posedge sys_clk);
        analog_sample <= s;
        chip_select_n <= cs;
        conversion_start_n <= 1'b0;
        @(posedge sys_clk);
        conversion_start_n <= 1'b1;
        analog_sample <= ~s;
    endtask

    task automatic read(input logic cs, output sapc_word_t d, output logic oe);
        @(posedge sys_clk);
        chip_select_n <= cs;
        read_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        d = result_bus;
        oe = result_bus_oe;
        read_n <= 1'b1;
        repeat (2) @(posedge sys_clk);
    endtask

    // Holds the read strobe at the given level, with the part selected, until the next call.
    task automatic hold_read(input logic on);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        read_n <= ~on;
    endtask

    task automatic power(input logic pd, input logic cs);
        @(posedge sys_clk);
        power_down_n <= pd;
        chip_select_n <= cs;
        if (pd) begin
            repeat (100) @(posedge sys_clk);
        end
    endtask
endmodule

`default_nettype wire

// *** tb/sar_adc_parallel_control_tb.sv ***
// Self-checking bench for the converter control and its FIFO.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_parallel_control_tb;
    import sapc_pkg::*;
    localparam int LOW_CYC = BIT_CYC * RES_BITS + 2 + LEAD_CYC;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic cs_n, cvs_n, rd_n, pd_n, busy, oe, nap, slp;
    sapc_word_t sample, res;
    int errors = 0;
    int tests_run = 0;

    sapc_core sapc_core_inst (.sys_clk(sys_clk), .rstn(rstn), .chip_select_n(cs_n),
        .conversion_start_n(cvs_n), .read_n(rd_n), .power_down_n(pd_n), .analog_sample(sample),
        .busy(busy), .result_bus(res), .result_bus_oe(oe), .nap_mode(nap), .sleep_mode(slp));
    sapc_host_model sapc_host_model_inst (.sys_clk(sys_clk), .result_bus(res), .result_bus_oe(oe),
        .chip_select_n(cs_n), .conversion_start_n(cvs_n), .read_n(rd_n), .power_down_n(pd_n),
        .analog_sample(sample));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("checks=%0d errors=%0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // A second start lands in mid-conversion and must neither restart nor stretch it.
    task automatic conv_test(input sapc_word_t exp);
        int n, ch;
        sapc_word_t d;
        logic o;
        n = 0;
        ch = -1;
        sapc_host_model_inst.start(exp, 1'b0);
        repeat (100) @(posedge sys_clk);
        check(16'(oe), 16'h0);
        sapc_host_model_inst.start(exp ^ 14'h0155, 1'b0);
        do begin
            @(posedge sys_clk);
            n++;
            if (ch < 0 && res === exp) begin
                ch = n;
            end
        end while (busy !== 1'b1 && n < 1000);
        check(16'(n + 101), 16'(LOW_CYC));
        check(16'(n + 101 <= ACQ_CONV_MAX_CYC), 16'h1);
        check(16'(ch > 0 && n - ch >= LEAD_CYC), 16'h1);
        sapc_host_model_inst.read(1'b0, d, o);
        check(16'(d), 16'(exp));
        check(16'(o), 16'h1);
        check(16'(oe), 16'h0);
        $display("conversion test done");
    endtask

    task automatic refuse_test();
        sapc_word_t d;
        logic o;
        sapc_host_model_inst.start(14'h0abc, 1'b1);
        repeat (8) @(posedge sys_clk);
        check(16'(busy), 16'h1);
        sapc_host_model_inst.read(1'b1, d, o);
        check(16'(o), 16'h0);
        sapc_host_model_inst.power(1'b0, 1'b0);
        repeat (2) @(posedge sys_clk);
        check(16'({nap, slp}), 16'h2);
        sapc_host_model_inst.start(14'h0abc, 1'b0);
        repeat (8) @(posedge sys_clk);
        check(16'(busy), 16'h1);
        sapc_host_model_inst.power(1'b0, 1'b1);
        repeat (2) @(posedge sys_clk);
        check(16'({nap, slp}), 16'h1);
        sapc_host_model_inst.power(1'b1, 1'b0);
        check(16'({nap, slp}), 16'h0);
        $display("refusal test done");
    endtask

    // A read held across the end of a conversion keeps the new word in the FIFO and busy low until it ends.
    task automatic fifo_test(input sapc_word_t exp);
        sapc_word_t old;
        int n;
        old = res;
        n = 0;
        sapc_host_model_inst.start(exp, 1'b0);
        sapc_host_model_inst.hold_read(1'b1);
        repeat (LOW_CYC + 40) @(posedge sys_clk);
        check(16'(busy), 16'h0);
        check(16'(res), 16'(old));
        check(16'(oe), 16'h1);
        sapc_host_model_inst.hold_read(1'b0);
        do begin
            @(posedge sys_clk);
            n++;
        end while (busy !== 1'b1 && n < 1000);
        // One cycle for the release to be seen, the lead time, and one cycle for busy to show.
        check(16'(n), 16'(LEAD_CYC + 2));
        check(16'(res), 16'(exp));
        check(16'(oe), 16'h0);
        $display("fifo test done");
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        complete_run();
    end

    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        check(16'({busy, oe, nap, slp}), 16'h8);
        conv_test(14'h3fff);
        conv_test(14'h2000);
        conv_test(14'h1fff);
        conv_test(14'h0000);
        refuse_test();
        conv_test(14'h1555);
        fifo_test(14'h2aaa);
        complete_run();
    end
endmodule

`default_nettype wire
